// ---- src/framer_status_pkg.sv ----
// Register map and field constants for the framer status and interrupt block
// Function
// (R1) Source select picks receive clock or pin
// (R2) Receive store reset rising edge realigns store
// (R3) Transmit store reset rising edge realigns store
// (R4) Host toggles receive reset, then clears it
// (R5) Status bits latch high on event
// (R6) Read clears; persistent alarms stay set
// (R7) Sync state register read-only, unlatched
// (R8) Mask write refreshes selected readable bits
// (R9) Host writes mask, reads, writes back
// (R10) Maskable active-low interrupt from three registers
// (R11) Four alarms interrupt on every change
// (R12) Alarm interrupt released when bit read
// (R13) Event interrupt released when bit read
// (R14) Summary shows status and HDLC pending
package framer_status_pkg;
    localparam int DATA_W = 8;
    localparam int ADDR_W = 8;
    localparam logic [7:0] ADDR_STATUS_ONE = 8'h06;
    localparam logic [7:0] ADDR_STATUS_TWO = 8'h07;
    localparam logic [7:0] ADDR_RX_INFO = 8'h08;
    localparam logic [7:0] ADDR_MASK_ONE = 8'h16;
    localparam logic [7:0] ADDR_MASK_TWO = 8'h17;
    localparam logic [7:0] ADDR_CLK_STORE_CTRL = 8'h1D;
    localparam logic [7:0] ADDR_SYNC_STATE = 8'h1E;
    localparam logic [7:0] ADDR_HDLC_STATUS = 8'h90;
    localparam logic [7:0] ADDR_HDLC_MASK = 8'h91;
    localparam logic [7:0] ADDR_SUMMARY_BASE = 8'hC0;
    localparam logic [7:0] SUMMARY_SPAN_MASK = 8'hC0;
    localparam logic [7:0] ZERO_BYTE = 8'h00;
    localparam logic [7:0] ONES_BYTE = 8'hFF;
    // Control register fields
    localparam int CTRL_TX_CLK_SRC_BIT = 2;
    localparam int CTRL_RX_RESET_BIT = 1;
    localparam int CTRL_TX_RESET_BIT = 0;
    localparam logic [7:0] CTRL_WRITE_MASK = 8'h07;
    localparam logic [7:0] CTRL_RESET_VALUE = 8'h00;
    // Low nibble of status one: alarms that interrupt on change of state
    localparam logic [7:0] CHANGE_ALARM_MASK = 8'h0F;
    localparam logic [3:0] CHANGE_RESET_VALUE = 4'h0;
    localparam int CHANGE_W = 4;
    // Summary register fields
    localparam int SUMMARY_STATUS_BIT = 0;
    localparam int SUMMARY_HDLC_BIT = 1;
endpackage : framer_status_pkg

// ---- src/framer_status_interrupt_logic.sv ----
// Per-framer latched status, interrupt and clock/store control logic
`timescale 1ns/1ns
module framer_status_interrupt_logic #(
    parameter int DATA_W = framer_status_pkg::DATA_W,
    parameter int ADDR_W = framer_status_pkg::ADDR_W
) (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic clock_enable,
    input wire logic cs,
    input wire logic rd_strobe,
    input wire logic wr_strobe,
    input wire logic [ADDR_W-1:0] address,
    input wire logic [DATA_W-1:0] wr_data,
    input wire logic [DATA_W-1:0] status_one_in,
    input wire logic [DATA_W-1:0] status_two_in,
    input wire logic [DATA_W-1:0] rx_info_in,
    input wire logic [DATA_W-1:0] hdlc_status_in,
    input wire logic [DATA_W-1:0] sync_state_in,
    output logic [DATA_W-1:0] rd_data,
    output logic int_n,
    output logic tx_clock_source_select,
    output logic transmit_clock_loss_mux_enable,
    output logic rx_store_realign,
    output logic tx_store_realign
);

    // ------------------------------------------------------------
    // Address decode
    // ------------------------------------------------------------
    wire logic wr_en = cs & wr_strobe;
    wire logic rd_en = cs & rd_strobe;
    wire logic sel_one = (address == framer_status_pkg::ADDR_STATUS_ONE);
    wire logic sel_two = (address == framer_status_pkg::ADDR_STATUS_TWO);
    wire logic sel_info = (address == framer_status_pkg::ADDR_RX_INFO);
    wire logic sel_hdlc = (address == framer_status_pkg::ADDR_HDLC_STATUS);
    wire logic sel_mask_one = (address == framer_status_pkg::ADDR_MASK_ONE);
    wire logic sel_mask_two = (address == framer_status_pkg::ADDR_MASK_TWO);
    wire logic sel_hmask = (address == framer_status_pkg::ADDR_HDLC_MASK);
    wire logic sel_ctrl = (address == framer_status_pkg::ADDR_CLK_STORE_CTRL);
    wire logic sel_sync = (address == framer_status_pkg::ADDR_SYNC_STATE);
    wire logic sel_sum = ((address & framer_status_pkg::SUMMARY_SPAN_MASK) == framer_status_pkg::ADDR_SUMMARY_BASE);

    // ------------------------------------------------------------
    // Latched status helpers
    // ------------------------------------------------------------
    // Set wins over the read clear so an event landing on the read is kept
    function automatic logic [DATA_W-1:0] latch_next(input logic [DATA_W-1:0] held,
                                                    input logic [DATA_W-1:0] seen,
                                                    input logic do_read,
                                                    input logic [DATA_W-1:0] incoming);
        latch_next = (held & ~(do_read ? seen : framer_status_pkg::ZERO_BYTE)) | incoming;
    endfunction : latch_next

    function automatic logic [DATA_W-1:0] view_next(input logic [DATA_W-1:0] view,
                                                   input logic do_write,
                                                   input logic [DATA_W-1:0] mask,
                                                   input logic [DATA_W-1:0] held);
        view_next = do_write ? ((mask & held) | (~mask & view)) : view;
    endfunction : view_next

    logic [DATA_W-1:0] one_reg;
    logic [DATA_W-1:0] two_reg;
    logic [DATA_W-1:0] info_reg;
    logic [DATA_W-1:0] hdlc_reg;
    logic [DATA_W-1:0] one_view_reg;
    logic [DATA_W-1:0] two_view_reg;
    logic [DATA_W-1:0] info_view_reg;
    logic [DATA_W-1:0] hdlc_view_reg;
    logic [DATA_W-1:0] mask_one_reg;
    logic [DATA_W-1:0] mask_two_reg;
    logic [DATA_W-1:0] hmask_reg;
    logic [DATA_W-1:0] ctrl_reg;
    logic [DATA_W-1:0] rd_data_reg;
    logic [framer_status_pkg::CHANGE_W-1:0] alarm_prev_reg;
    logic [framer_status_pkg::CHANGE_W-1:0] change_reg;
    logic int_n_reg;
    logic rx_realign_reg;
    logic tx_realign_reg;
    logic loss_mux_reg;

    // Alarms are levels, events are pulses; one OR covers both behaviours
    wire logic [DATA_W-1:0] one_next = latch_next(one_reg, one_view_reg, rd_en & sel_one, status_one_in); // R5 R6
    wire logic [DATA_W-1:0] two_next = latch_next(two_reg, two_view_reg, rd_en & sel_two, status_two_in); // R5 R6
    wire logic [DATA_W-1:0] info_next = latch_next(info_reg, info_view_reg, rd_en & sel_info, rx_info_in); // R5 R6
    wire logic [DATA_W-1:0] hdlc_next = latch_next(hdlc_reg, hdlc_view_reg, rd_en & sel_hdlc, hdlc_status_in);

    wire logic [DATA_W-1:0] one_view_next = view_next(one_view_reg, wr_en & sel_one, wr_data, one_reg); // R8
    wire logic [DATA_W-1:0] two_view_next = view_next(two_view_reg, wr_en & sel_two, wr_data, two_reg); // R8
    wire logic [DATA_W-1:0] info_view_next = view_next(info_view_reg, wr_en & sel_info, wr_data, info_reg); // R8
    wire logic [DATA_W-1:0] hdlc_view_next = view_next(hdlc_view_reg, wr_en & sel_hdlc, wr_data, hdlc_reg);

    // ------------------------------------------------------------
    // Change-of-state alarm interrupts
    // ------------------------------------------------------------
    wire logic [framer_status_pkg::CHANGE_W-1:0] alarm_now = status_one_in[framer_status_pkg::CHANGE_W-1:0];
    wire logic [framer_status_pkg::CHANGE_W-1:0] alarm_edge = alarm_now ^ alarm_prev_reg; // R11
    wire logic [framer_status_pkg::CHANGE_W-1:0] change_clear =
        (rd_en & sel_one) ? one_view_reg[framer_status_pkg::CHANGE_W-1:0] : framer_status_pkg::CHANGE_RESET_VALUE;
    wire logic [framer_status_pkg::CHANGE_W-1:0] change_next = (change_reg & ~change_clear) | alarm_edge; // R12

    // ------------------------------------------------------------
    // Interrupt sources and summary
    // ------------------------------------------------------------
    wire logic [DATA_W-1:0] one_src = (one_reg & ~framer_status_pkg::CHANGE_ALARM_MASK)
                                    | {{(DATA_W-framer_status_pkg::CHANGE_W){1'b0}}, change_reg}; // R11 R13
    wire logic status_pending = |(one_src & mask_one_reg) | |(two_reg & mask_two_reg); // R10 R13
    wire logic hdlc_pending = |(hdlc_reg & hmask_reg); // R10
    wire logic [DATA_W-1:0] summary = {{(DATA_W-2){1'b0}}, hdlc_pending, status_pending}; // R14

    // ------------------------------------------------------------
    // Control register
    // ------------------------------------------------------------
    wire logic [DATA_W-1:0] ctrl_next = (wr_en & sel_ctrl) ? (wr_data & framer_status_pkg::CTRL_WRITE_MASK) : ctrl_reg;
    wire logic rx_rise = ctrl_next[framer_status_pkg::CTRL_RX_RESET_BIT]
                       & ~ctrl_reg[framer_status_pkg::CTRL_RX_RESET_BIT]; // R2 R4
    wire logic tx_rise = ctrl_next[framer_status_pkg::CTRL_TX_RESET_BIT]
                       & ~ctrl_reg[framer_status_pkg::CTRL_TX_RESET_BIT]; // R3

    // ------------------------------------------------------------
    // Read mux
    // ------------------------------------------------------------
    // Unmapped addresses read zero
    wire logic [DATA_W-1:0] rd_mux =
        sel_one ? one_view_reg :
        sel_two ? two_view_reg :
        sel_info ? info_view_reg :
        sel_hdlc ? hdlc_view_reg :
        sel_mask_one ? mask_one_reg :
        sel_mask_two ? mask_two_reg :
        sel_hmask ? hmask_reg :
        sel_ctrl ? ctrl_reg :
        sel_sync ? sync_state_in : // R7
        sel_sum ? summary :
        framer_status_pkg::ZERO_BYTE;

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            one_reg <= framer_status_pkg::ZERO_BYTE;
            two_reg <= framer_status_pkg::ZERO_BYTE;
            info_reg <= framer_status_pkg::ZERO_BYTE;
            hdlc_reg <= framer_status_pkg::ZERO_BYTE;
            one_view_reg <= framer_status_pkg::ZERO_BYTE;
            two_view_reg <= framer_status_pkg::ZERO_BYTE;
            info_view_reg <= framer_status_pkg::ZERO_BYTE;
            hdlc_view_reg <= framer_status_pkg::ZERO_BYTE;
        end else if (clock_enable) begin
            one_reg <= one_next;
            two_reg <= two_next;
            info_reg <= info_next;
            hdlc_reg <= hdlc_next;
            one_view_reg <= one_view_next;
            two_view_reg <= two_view_next;
            info_view_reg <= info_view_next;
            hdlc_view_reg <= hdlc_view_next;
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            mask_one_reg <= framer_status_pkg::ZERO_BYTE;
            mask_two_reg <= framer_status_pkg::ZERO_BYTE;
            hmask_reg <= framer_status_pkg::ZERO_BYTE;
        end else if (clock_enable && wr_en) begin
            if (sel_mask_one) begin
                mask_one_reg <= wr_data;
            end
            if (sel_mask_two) begin
                mask_two_reg <= wr_data;
            end
            if (sel_hmask) begin
                hmask_reg <= wr_data;
            end
        end
    end

    // Previous alarm starts at zero, so an alarm present at reset interrupts once
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            alarm_prev_reg <= framer_status_pkg::CHANGE_RESET_VALUE;
            change_reg <= framer_status_pkg::CHANGE_RESET_VALUE;
            int_n_reg <= 1'b1;
        end else if (clock_enable) begin
            alarm_prev_reg <= alarm_now;
            change_reg <= change_next;
            int_n_reg <= ~(status_pending | hdlc_pending); // R10
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            ctrl_reg <= framer_status_pkg::CTRL_RESET_VALUE;
            loss_mux_reg <= ~framer_status_pkg::CTRL_RESET_VALUE[framer_status_pkg::CTRL_TX_CLK_SRC_BIT];
            rx_realign_reg <= 1'b0;
            tx_realign_reg <= 1'b0;
        end else if (clock_enable) begin
            ctrl_reg <= ctrl_next;
            // Own flop so the pin needs no inverter after the register
            loss_mux_reg <= ~ctrl_next[framer_status_pkg::CTRL_TX_CLK_SRC_BIT]; // R1
            rx_realign_reg <= rx_rise; // R2
            tx_realign_reg <= tx_rise; // R3
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            rd_data_reg <= framer_status_pkg::ZERO_BYTE;
        end else if (clock_enable && rd_en) begin
            rd_data_reg <= rd_mux;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign rd_data = rd_data_reg;
    assign int_n = int_n_reg;
    assign tx_clock_source_select = ctrl_reg[framer_status_pkg::CTRL_TX_CLK_SRC_BIT]; // R1
    assign transmit_clock_loss_mux_enable = loss_mux_reg; // R1
    assign rx_store_realign = rx_realign_reg;
    assign tx_store_realign = tx_realign_reg;

endmodule : framer_status_interrupt_logic

// ---- tb/framer_status_properties.sv ----
// Checker for the framer status interrupt logic
`timescale 1ns/1ns
module framer_status_properties (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic clock_enable,
    input wire logic cs,
    input wire logic rd_strobe,
    input wire logic wr_strobe,
    input wire logic [7:0] address,
    input wire logic [7:0] wr_data,
    input wire logic [7:0] sync_state_in,
    input wire logic [7:0] rd_data,
    input wire logic int_n,
    input wire logic tx_clock_source_select,
    input wire logic transmit_clock_loss_mux_enable,
    input wire logic rx_store_realign,
    input wire logic tx_store_realign
);
    default clocking @(posedge clock); endclocking
    default disable iff (!rst_n);
    wire bus_go = clock_enable && cs && (rd_strobe || wr_strobe);
    wire rd_go = bus_go && rd_strobe;
    wire ctrl_wr = bus_go && wr_strobe && address == framer_status_pkg::ADDR_CLK_STORE_CTRL;
    wire rx_set = ctrl_wr && wr_data[1];
    wire tx_set = ctrl_wr && wr_data[0];
    clk_source_a: assert property (ctrl_wr |=> tx_clock_source_select == $past(wr_data[2]))
        else $error("clock source select mismatch");
    mux_inverse_a: assert property (transmit_clock_loss_mux_enable == !tx_clock_source_select)
        else $error("loss mux enable mismatch");
    rx_realign_a: assert property (rx_store_realign |-> $past(rx_set) ##1 !rx_store_realign)
        else $error("receive realign pulse wrong");
    tx_realign_a: assert property (tx_store_realign |-> $past(tx_set) ##1 !tx_store_realign)
        else $error("transmit realign pulse wrong");
    sync_view_a: assert property (rd_go && address == 8'h1E |=> rd_data == $past(sync_state_in))
        else $error("sync state read wrong");
    summary_pad_a: assert property (rd_go && address[7:6] == 2'b11 |=> rd_data[7:2] == 6'h00)
        else $error("summary upper bits set");
    read_hold_a: assert property (!rd_go |=> $stable(rd_data))
        else $error("read data moved without read");
    int_release_a: assert property ($rose(int_n) |-> $past(bus_go, 2))
        else $error("interrupt released without access");
endmodule : framer_status_properties

bind framer_status_interrupt_logic framer_status_properties chk_i (.clock(clock), .rst_n(rst_n),
    .clock_enable(clock_enable), .cs(cs), .rd_strobe(rd_strobe), .wr_strobe(wr_strobe), .address(address),
    .wr_data(wr_data), .sync_state_in(sync_state_in), .rd_data(rd_data), .int_n(int_n),
    .tx_clock_source_select(tx_clock_source_select),
    .transmit_clock_loss_mux_enable(transmit_clock_loss_mux_enable),
    .rx_store_realign(rx_store_realign), .tx_store_realign(tx_store_realign));

// ---- tb/host_model.sv ----
// Host processor model on the parallel control port
`timescale 1ns/1ns
module host_model (
    input wire logic clock,
    input wire logic [7:0] rd_data,
    output logic cs = 1'b0,
    output logic rd_strobe = 1'b0,
    output logic wr_strobe = 1'b0,
    output logic [7:0] address = 8'h00,
    output logic [7:0] wr_data = 8'h00
);
    // Idle bus shows inverted values so stale data is never trusted
    task automatic access(input logic [7:0] a, input logic [7:0] d, input logic w);
        @(posedge clock);
        cs <= 1'b1;
        rd_strobe <= !w;
        wr_strobe <= w;
        address <= a;
        wr_data <= d;
        @(posedge clock);
        cs <= 1'b0;
        rd_strobe <= 1'b0;
        wr_strobe <= 1'b0;
        address <= ~a;
        wr_data <= ~d;
    endtask : access
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        access(a, d, 1'b1);
    endtask : wr
    task automatic rd(input logic [7:0] a, output logic [7:0] q);
        access(a, 8'h00, 1'b0);
        #1 q = rd_data;
    endtask : rd
    task automatic poll(input logic [7:0] a, input logic [7:0] m, output logic [7:0] q);
        wr(a, m);
        rd(a, q);
        wr(a, q & m);
    endtask : poll
endmodule : host_model

// ---- tb/tb_top.sv ----
// Self-checking bench for the framer status interrupt logic
`timescale 1ns/1ns
module tb_top;
    logic clock = 1'b0;
    logic rst_n = 1'b0;
    logic clk_en = 1'b1;
    logic [7:0] stat1 = 8'h00, stat2 = 8'h00, info = 8'h00, hdlc = 8'h00, sync = 8'h00, q;
    wire cs, rd_strobe, wr_strobe, int_n, sel, mux_en, rx_re, tx_re;
    wire [7:0] address, wr_data, rd_data;
    int errors = 0;
    int checks = 0;
    framer_status_interrupt_logic dut (.clock(clock), .rst_n(rst_n), .clock_enable(clk_en), .cs(cs),
        .rd_strobe(rd_strobe), .wr_strobe(wr_strobe), .address(address), .wr_data(wr_data),
        .status_one_in(stat1), .status_two_in(stat2), .rx_info_in(info), .hdlc_status_in(hdlc),
        .sync_state_in(sync), .rd_data(rd_data), .int_n(int_n), .tx_clock_source_select(sel),
        .transmit_clock_loss_mux_enable(mux_en), .rx_store_realign(rx_re), .tx_store_realign(tx_re));
    host_model host (.clock(clock), .rd_data(rd_data), .cs(cs), .rd_strobe(rd_strobe),
        .wr_strobe(wr_strobe), .address(address), .wr_data(wr_data));
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        checks++;
        if (seen !== exp) begin
            errors++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : chk
    task automatic conclude();
        $display("errors %0d checks %0d", errors, checks);
        if (errors == 0 && checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : conclude
    // Registered interrupt needs two edges; three leaves margin
    task automatic settle();
        repeat (3) @(posedge clock);
    endtask : settle
    initial begin
        forever #20 clock = ~clock;
    end
    // Whole run is under two hundred cycles
    initial begin
        repeat (3000) @(posedge clock);
        errors++;
        conclude();
    end
    initial begin
        repeat (3) @(posedge clock);
        rst_n <= 1'b1;
        #1 chk({7'h00, int_n}, 8'h01);
        chk({6'h00, sel, mux_en}, 8'h01);
        host.wr(8'h1D, 8'h04);
        #1 chk({6'h00, sel, mux_en}, 8'h02);
        host.wr(8'h1D, 8'h06);
        #1 chk({6'h00, rx_re, tx_re}, 8'h02);
        host.wr(8'h1D, 8'h01);
        #1 chk({5'h00, sel, rx_re, tx_re}, 8'h01);
        host.wr(8'h1D, 8'h00);
        host.rd(8'h1D, q);
        chk(q, 8'h00);
        // Frozen clock enable must drop the write
        @(posedge clock) clk_en <= 1'b0;
        host.wr(8'h1D, 8'h04);
        #1 chk({7'h00, sel}, 8'h00);
        @(posedge clock) clk_en <= 1'b1;
        $display("control test done");
        @(posedge clock) sync <= 8'hA5;
        host.wr(8'h1E, 8'h00);
        host.rd(8'h1E, q);
        chk(q, 8'hA5);
        host.rd(8'h50, q);
        chk(q, 8'h00);
        $display("sync test done");
        host.wr(8'h16, 8'h10);
        @(posedge clock) stat1 <= 8'h10;
        @(posedge clock) stat1 <= 8'h00;
        settle();
        chk({7'h00, int_n}, 8'h00);
        host.poll(8'h06, 8'h10, q);
        chk(q, 8'h10);
        settle();
        chk({7'h00, int_n}, 8'h01);
        @(posedge clock) stat1 <= 8'h10;
        @(posedge clock) stat1 <= 8'h00;
        // Zero mask keeps the old cleared view although the bit is latched again
        host.wr(8'h06, 8'h00);
        host.rd(8'h06, q);
        chk(q, 8'h00);
        host.poll(8'h06, 8'h10, q);
        chk(q, 8'h10);
        host.poll(8'h06, 8'h10, q);
        chk(q, 8'h00);
        $display("event test done");
        host.wr(8'h16, 8'h01);
        @(posedge clock) stat1 <= 8'h01;
        settle();
        chk({7'h00, int_n}, 8'h00);
        host.poll(8'h06, 8'h01, q);
        settle();
        chk({q[6:0], int_n}, 8'h03);
        host.poll(8'h06, 8'h01, q);
        chk(q, 8'h01);
        @(posedge clock) stat1 <= 8'h00;
        settle();
        chk({7'h00, int_n}, 8'h00);
        host.poll(8'h06, 8'h01, q);
        settle();
        chk({q[6:0], int_n}, 8'h03);
        host.poll(8'h06, 8'h01, q);
        chk(q, 8'h00);
        $display("alarm test done");
        host.wr(8'h91, 8'h01);
        @(posedge clock) hdlc <= 8'h01;
        settle();
        chk({7'h00, int_n}, 8'h00);
        host.rd(8'hC7, q);
        chk(q, 8'h02);
        host.wr(8'h91, 8'h00);
        settle();
        chk({7'h00, int_n}, 8'h01);
        hdlc <= 8'h00;
        host.wr(8'h17, 8'h80);
        @(posedge clock) stat2 <= 8'h80;
        @(posedge clock) stat2 <= 8'h00;
        settle();
        host.rd(8'hC0, q);
        chk({q[6:0], int_n}, 8'h02);
        host.poll(8'h07, 8'h80, q);
        chk(q, 8'h80);
        settle();
        chk({7'h00, int_n}, 8'h01);
        @(posedge clock) info <= 8'h08;
        @(posedge clock) info <= 8'h00;
        host.poll(8'h08, 8'h08, q);
        chk(q, 8'h08);
        $display("interrupt test done");
        conclude();
    end
endmodule : tb_top
